// ---- dv/dce_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module dce_chk(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic [1:0] m0_htrans,
	input wire logic [31:0] m0_haddr,
	input wire logic m0_hready,
	input wire logic [1:0] m1_htrans,
	input wire logic [15:0] dma_req,
	input wire logic [15:0] dma_ack,
	input wire logic [5:0] completion_output_pulse,
	input wire logic completion_interrupt_line,
	input wire logic dma_irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------
	// Checks
	// ----------------------
	cap_read_a: assert property (hsel && hready && htrans[1] &&
		!hwrite && haddr[11:0] == 12'h034 |=> hrdata == 32'h0000_6103)
		else $error("cap");
	pulse_one_a: assert property (completion_output_pulse != 6'h0 |=>
		(completion_output_pulse & $past(completion_output_pulse)) == 6'h0)
		else $error("pulse width");
	pulse_excl_a: assert property ($onehot0(completion_output_pulse))
		else $error("two pulses");
	irq_or_a: assert property (completion_interrupt_line |-> dma_irq)
		else $error("irq");
	ack_drop_a: assert property (dma_ack != 16'h0 &&
		(dma_ack & dma_req) == 16'h0 |=> dma_ack == 16'h0) else $error("ack");
	ack_hold_a: assert property ((dma_ack & dma_req) != 16'h0 |=>
		$stable(dma_ack)) else $error("ack hold");
	one_master_a: assert property (!(m0_htrans[1] && m1_htrans[1]))
		else $error("both masters");
	addr_hold_a: assert property (m0_htrans[1] && !m0_hready |=>
		m0_htrans[1] && $stable(m0_haddr)) else $error("addr hold");
	cover property (completion_output_pulse[0]);
	cover property (dma_ack[2]);
	cover property (m1_htrans[1]);
endmodule
bind dce_engine dce_chk dce_chk_inst(.sys_clk, .rst, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hrdata, .m0_htrans, .m0_haddr, .m0_hready, .m1_htrans,
	.dma_req, .dma_ack, .completion_output_pulse, .completion_interrupt_line,
	.dma_irq);
`default_nettype wire

// ---- dv/dce_far.sv ----
`timescale 1ns/1ps
`default_nettype none
module dce_far #(
	parameter logic [31:0] BAD = 32'h0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] htrans,
	input wire logic [31:0] haddr,
	output logic [31:0] hrdata,
	output logic hready,
	output logic hresp
);
	logic [1:0] ph_ff;
	logic [32:0] dat_ff;
	// Slave stalls on address bit 4 or BAD, and answers ERROR for BAD in two cycles
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ph_ff <= 2'h0;
			dat_ff <= 33'h0;
		end else if (htrans[1] && hready) begin
			ph_ff <= (haddr[4] || haddr == BAD) ? 2'h2 : 2'h1;
			dat_ff <= {haddr == BAD, haddr ^ 32'h5a5a_a5a5};
		end else if (ph_ff != 2'h0) begin
			ph_ff <= ph_ff - 2'h1;
		end
	end
	// Data only in the last data cycle, inverted once released
	assign hready = ph_ff != 2'h2;
	assign hresp = dat_ff[32] && ph_ff != 2'h0;
	assign hrdata = ph_ff == 2'h1 ? dat_ff[31:0] : ~dat_ff[31:0];
endmodule
`default_nettype wire

// ---- dv/tb_dce_engine.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_dce_engine;
	logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, m0_htrans, m1_htrans;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, m0_haddr, m1_haddr;
	logic [31:0] m0_hrdata, m1_hrdata, m0_hwdata;
	logic m0_hready, m0_hresp, m1_hready, m1_hresp;
	logic [15:0] dma_req = 16'h0, dma_ack;
	logic [5:0] completion_output_pulse;
	logic completion_interrupt_line, dma_irq;
	int fails = 0, n_compared = 0;
	logic [5:0] seen_pulse = 6'h0;
	always #5 sys_clk = ~sys_clk;
	// Collects every completion pulse for the closing check
	always @(posedge sys_clk) begin
		if (!rst) begin
			seen_pulse <= seen_pulse | completion_output_pulse;
		end
	end
	dce_engine dce_engine_inst(.sys_clk, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(1'b1), .hreadyout(), .hresp(),
		.hrdata, .m0_haddr, .m0_htrans, .m0_hwrite(), .m0_hsize(), .m0_hwdata,
		.m0_hrdata, .m0_hready, .m0_hresp, .m1_haddr, .m1_htrans, .m1_hwrite(),
		.m1_hsize(), .m1_hwdata(), .m1_hrdata, .m1_hready, .m1_hresp, .dma_req,
		.dma_ack, .completion_output_pulse, .completion_interrupt_line, .dma_irq);
	dce_far #(.BAD(32'h40)) dce_far_inst(.sys_clk, .rst, .htrans(m0_htrans),
		.haddr(m0_haddr), .hrdata(m0_hrdata), .hready(m0_hready), .hresp(m0_hresp));
	dce_far dce_far_inst1(.sys_clk, .rst, .htrans(m1_htrans), .haddr(m1_haddr),
		.hrdata(m1_hrdata), .hready(m1_hready), .hresp(m1_hresp));
	// ----------------------
	// Bus tasks
	// ----------------------
	task automatic stop_test();
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
		@(negedge sys_clk);
		{hsel, htrans, hwrite, haddr} = {1'b1, 2'h2, w, 20'h0, a};
		@(negedge sys_clk);
		{hsel, htrans, hwdata} = {1'b0, 2'h0, d};
	endtask
	// Read, retrying up to lim times while the value differs
	task automatic rd(logic [11:0] a, logic [31:0] e, string n, int lim = 1);
		for (int i = 0; i < lim; i++) begin
			xfer(1'b0, a, 32'h0);
			if (hrdata === e) break;
		end
		chk(n, hrdata, e);
		if (lim > 1 && hrdata !== e) stop_test();
	endtask
	task automatic wr(logic [11:0] a, logic [31:0] d);
		xfer(1'b1, a, d);
		@(negedge sys_clk);
	endtask
	// ----------------------
	// Sequence
	// ----------------------
	initial begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		rd(12'h034, 32'h0000_6103, "cap");
		wr(12'h034, 32'h0);
		rd(12'h034, 32'h0000_6103, "cap ro");
		rd(12'h100, 32'h0000_1200, "ctrl");
		rd(12'h104, 32'h0000_2087, "cfg");
		rd(12'h3fc, 32'h0, "unmapped");
		wr(12'h108, 32'h100);
		wr(12'h10c, 32'h200);
		wr(12'h114, 32'h2);
		wr(12'h100, 32'h0000_120d);
		rd(12'h014, 32'h1, "tc0", 300);
		rd(12'h108, 32'h108, "src end");
		rd(12'h10c, 32'h1f8, "dst end");
		rd(12'h114, 32'h0, "size");
		chk("tc line", {31'h0, completion_interrupt_line}, 32'h0);
		chk("irq", {31'h0, dma_irq}, 32'h0);
		wr(12'h104, 32'h0000_0086);
		chk("tc line", {31'h0, completion_interrupt_line}, 32'h1);
		chk("irq", {31'h0, dma_irq}, 32'h1);
		wr(12'h128, 32'h40);
		wr(12'h134, 32'h1);
		wr(12'h120, 32'h0000_1201);
		rd(12'h018, 32'h2, "err", 300);
		wr(12'h148, 32'h300);
		wr(12'h14c, 32'h400);
		wr(12'h154, 32'h1);
		wr(12'h144, 32'h0000_0097);
		wr(12'h140, 32'h0000_1281);
		repeat (40) @(negedge sys_clk);
		rd(12'h014, 32'h1, "no req");
		dma_req[dce_pkg::REQ_CODEC_IN] = 1'b1;
		for (int i = 0; i < 300 && dma_ack[2] !== 1'b1; i++) @(negedge sys_clk);
		chk("ack", {31'h0, dma_ack[2]}, 32'h1);
		if (dma_ack[2] !== 1'b1) stop_test();
		repeat (2) @(negedge sys_clk);
		chk("ack held", {31'h0, dma_ack[2]}, 32'h1);
		dma_req[2] = 1'b0;
		rd(12'h014, 32'h5, "tc2", 300);
		chk("wdata", m0_hwdata, 32'h5a5a_a6a5);
		wr(12'h174, 32'h1);
		wr(12'h160, 32'h0000_1281);
		wr(12'h160, 32'h0000_9281);
		rd(12'h018, 32'h0008_0002, "abt", 300);
		chk("pulses", {26'h0, seen_pulse}, 32'h5);
		stop_test();
	end
endmodule
`default_nettype wire

// ---- rtl/dce_engine.sv ----
// Contract
// - Threshold code maps 1,2,4,8,16; others 1
// - Fetch only when free space reaches threshold
// - Drain only when count exceeds threshold, or to flush once the burst has no reads left
// - Two-bit priority, 3 highest, resets 0
// - Burst code maps 1 to 256 units
// - Abort bit stops transfer, sets abort status
// - Width fields 8/16/32; hardware packs bytes
// - Mode bit selects normal or handshake
// - Address control increments, decrements or holds
// - Select bits route sides to master 0/1
// - Chain counter clears on enable rising
// - Side handshake enable gates request wait
// - Request-select fields pick peripheral lines
// - Read-only busy flag while transferring
// - Abort, error, completion masks; 1 masks
// - Status mask suppresses completion status set
// - Address registers keep final ending addresses
// - Descriptor pointer word address plus master bit
// - Total size counted in source width units
// - Read-only capability register reads 0x6103
// - Request lines map to fixed peripherals
// - Burst, then acknowledge until request drops
// - Completion sets status, pulses, raises interrupts
// - Bus error sets error status, stops
// - Highest priority wins, round robin within
`timescale 1ns/1ps
`default_nettype none
module dce_engine
	import dce_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic [31:0] m0_haddr,
	output logic [1:0] m0_htrans,
	output logic m0_hwrite,
	output logic [2:0] m0_hsize,
	output logic [31:0] m0_hwdata,
	input wire logic [31:0] m0_hrdata,
	input wire logic m0_hready,
	input wire logic m0_hresp,
	output logic [31:0] m1_haddr,
	output logic [1:0] m1_htrans,
	output logic m1_hwrite,
	output logic [2:0] m1_hsize,
	output logic [31:0] m1_hwdata,
	input wire logic [31:0] m1_hrdata,
	input wire logic m1_hready,
	input wire logic m1_hresp,
	input wire logic [REQ_LINES-1:0] dma_req,
	output logic [REQ_LINES-1:0] dma_ack,
	output logic [NCH-1:0] completion_output_pulse,
	output logic completion_interrupt_line,
	output logic dma_irq
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic [31:0] ctrl_ff [NCH];
	logic [31:0] cfg_ff [NCH];
	logic [31:0] sa_ff [NCH];
	logic [31:0] da_ff [NCH];
	logic [31:0] llp_ff [NCH];
	logic [31:0] sz_ff [NCH];
	logic [NCH-1:0] tc_st_ff, err_st_ff, abt_st_ff, abort_pend_ff;
	logic [NCH-1:0] tc_pulse_ff;
	logic s_wr_ff;
	logic [11:0] s_addr_ff;
	logic [31:0] s_rdata_ff;
	dce_state_t state_ff;
	logic [CH_W-1:0] gnt_ff, last_ff;
	logic [8:0] burst_ff;
	logic [1:0] pix_ff;
	logic [31:0] rbuf_ff, wbuf_ff;
	logic [31:0] m_addr_ff, m_wdata_ff;
	logic [1:0] m_trans_ff;
	logic m_write_ff, m_sel_ff;
	logic [2:0] m_size_ff;
	logic [REQ_LINES-1:0] ack_ff;
	logic [FIFO_AW-1:0] wptr_ff, rptr_ff;
	logic [FIFO_AW:0] cnt_ff;
	logic [7:0] fifo_rd_data;

	// ---------------------------------------------------------------
	// Granted channel view
	// ---------------------------------------------------------------
	logic [31:0] cur_ctrl, cur_cfg, cur_sa, cur_da, cur_sz, wword;
	logic [2:0] sbytes, dbytes;
	logic [4:0] th;
	logic [FIFO_AW:0] free;
	logic hs, need_s, need_d, no_more_rd, can_rd, can_wr;
	logic [3:0] srs, drs;
	logic m_hready, m_hresp;
	logic [31:0] m_hrdata;
	logic rd_ok, wr_ok, bus_err, end_done, end_abort, stop_ch;

	assign cur_ctrl = ctrl_ff[gnt_ff];
	assign cur_cfg = cfg_ff[gnt_ff];
	assign cur_sa = sa_ff[gnt_ff];
	assign cur_da = da_ff[gnt_ff];
	assign cur_sz = sz_ff[gnt_ff];
	assign sbytes = width_bytes(cur_ctrl[CT_SW +: 3]);
	assign dbytes = width_bytes(cur_ctrl[CT_DW +: 3]);
	assign th = th_decode(cur_ctrl[CT_TH +: 3]);
	assign free = (FIFO_AW + 1)'(FIFO_DEPTH) - cnt_ff;
	assign hs = cur_ctrl[CT_MODE];
	assign need_s = hs & cur_cfg[CF_SHE];
	assign need_d = hs & cur_cfg[CF_DHE];
	assign srs = cur_cfg[CF_SRS +: 4];
	assign drs = cur_cfg[CF_DRS +: 4];
	assign no_more_rd = (burst_ff == 9'h000) || (cur_sz == 32'h0);
	// Fetch needs room for both the threshold and one source unit
	assign can_rd = !no_more_rd && ({1'b0, free} >= th)
		&& (free >= {1'b0, sbytes});
	// Drain past threshold, or flush what the burst left behind
	assign can_wr = (cnt_ff >= {1'b0, dbytes})
		&& (({1'b0, cnt_ff} > th) || no_more_rd);
	assign wword = wbuf_ff | (32'(fifo_rd_data) << {pix_ff, 3'h0});

	// Selected master return path
	assign m_hready = m_sel_ff ? m1_hready : m0_hready;
	assign m_hresp = m_sel_ff ? m1_hresp : m0_hresp;
	assign m_hrdata = m_sel_ff ? m1_hrdata : m0_hrdata;
	assign rd_ok = (state_ff == ST_RD) && m_hready && !m_hresp;
	assign wr_ok = (state_ff == ST_WD) && m_hready && !m_hresp;
	assign bus_err = ((state_ff == ST_RD) || (state_ff == ST_WD))
		&& m_hresp;
	assign end_done = (state_ff == ST_END) && (cur_sz == 32'h0);
	assign end_abort = (state_ff == ST_END) && !end_done
		&& abort_pend_ff[gnt_ff];
	assign stop_ch = end_done || end_abort || bus_err;

	// Master outputs; only the selected port carries a transfer
	assign m0_haddr = m_addr_ff;
	assign m1_haddr = m_addr_ff;
	assign m0_hwrite = m_write_ff;
	assign m1_hwrite = m_write_ff;
	assign m0_hsize = m_size_ff;
	assign m1_hsize = m_size_ff;
	assign m0_hwdata = m_wdata_ff;
	assign m1_hwdata = m_wdata_ff;
	assign m0_htrans = m_sel_ff ? HTRANS_IDLE : m_trans_ff;
	assign m1_htrans = m_sel_ff ? m_trans_ff : HTRANS_IDLE;
	assign dma_ack = ack_ff;
	assign completion_output_pulse = tc_pulse_ff;

	// ---------------------------------------------------------------
	// Per-channel status views
	// ---------------------------------------------------------------
	logic [NCH-1:0] en_vec, busy_vec, tcm_vec, errm_vec, abtm_vec, elig;
	logic [NCH-1:0] int_tc, int_err, int_abt;

	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			en_vec[c] = ctrl_ff[c][CT_EN];
			busy_vec[c] = (state_ff != ST_ARB)
				&& (gnt_ff == CH_W'(c));
			tcm_vec[c] = cfg_ff[c][CF_TCM];
			errm_vec[c] = cfg_ff[c][CF_ERRM];
			abtm_vec[c] = cfg_ff[c][CF_ABTM];
		end
	end
	assign elig = en_vec;
	assign int_tc = tc_st_ff & ~tcm_vec;
	assign int_err = err_st_ff & ~errm_vec;
	assign int_abt = abt_st_ff & ~abtm_vec;
	assign completion_interrupt_line = |int_tc;
	assign dma_irq = |(int_tc | int_err | int_abt);

	// ---------------------------------------------------------------
	// Arbiter
	// ---------------------------------------------------------------
	logic arb_hit;
	logic [CH_W-1:0] arb_ch, arb_idx;
	logic [1:0] arb_best;

	// Scan from the channel after the last grant; strict compare
	// keeps the earliest of equal priority
	always_comb begin
		arb_hit = 1'b0;
		arb_ch = last_ff;
		arb_best = 2'h0;
		arb_idx = last_ff;
		for (int k = 1; k <= NCH; k++) begin
			arb_idx = CH_W'((int'(last_ff) + k) % NCH);
			if (elig[arb_idx] && (!arb_hit
				|| ctrl_ff[arb_idx][CT_PRI +: 2] > arb_best)) begin
				arb_hit = 1'b1;
				arb_ch = arb_idx;
				arb_best = ctrl_ff[arb_idx][CT_PRI +: 2];
			end
		end
	end

	// ---------------------------------------------------------------
	// Register slave
	// ---------------------------------------------------------------
	logic [11:0] ra;
	logic [CH_W-1:0] rch, sw_ch;
	logic [31:0] rd_word;
	logic sw_ch_hit, s_take;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = s_rdata_ff;
	assign ra = haddr[11:0];
	assign rch = ra[7:5];
	assign sw_ch = s_addr_ff[7:5];
	assign sw_ch_hit = (s_addr_ff[11:8] == OFS_CH_PAGE)
		&& (sw_ch < CH_W'(NCH));
	assign s_take = hsel && hready && htrans[1];

	// Read word for the address phase; unmapped reads give zero
	always_comb begin
		rd_word = 32'h0;
		if ((ra[11:8] == OFS_CH_PAGE) && (rch < CH_W'(NCH))) begin
			unique case (ra[4:0])
				OFS_C_CTRL: rd_word = ctrl_ff[rch];
				OFS_C_CFG: rd_word = cfg_ff[rch]
					| (32'(busy_vec[rch]) << CF_BUSY);
				OFS_C_SRC: rd_word = sa_ff[rch];
				OFS_C_DST: rd_word = da_ff[rch];
				OFS_C_LLP: rd_word = llp_ff[rch];
				OFS_C_SIZE: rd_word = sz_ff[rch];
				default: rd_word = 32'h0;
			endcase
		end else begin
			unique case (ra)
				OFS_INT: rd_word = 32'(int_tc | int_err | int_abt);
				OFS_INT_TC: rd_word = 32'(int_tc);
				OFS_INT_EA: rd_word = (32'(int_abt) << 16) | 32'(int_err);
				OFS_TC: rd_word = 32'(tc_st_ff);
				OFS_EA: rd_word = (32'(abt_st_ff) << 16) | 32'(err_st_ff);
				OFS_CHEN: rd_word = 32'(en_vec);
				OFS_BUSY: rd_word = 32'(busy_vec);
				OFS_CAP: rd_word = CAP_RESET;
				default: rd_word = 32'h0;
			endcase
		end
	end

	// Address phase capture and registered read data
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_wr_ff <= 1'b0;
			s_addr_ff <= 12'h000;
			s_rdata_ff <= 32'h0;
		end else begin
			s_wr_ff <= s_take && hwrite && (hsize == WID_32);
			if (s_take) begin
				s_addr_ff <= ra;
			end
			if (s_take && !hwrite) begin
				s_rdata_ff <= rd_word;
			end
		end
	end

	// ---------------------------------------------------------------
	// Channel registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int c = 0; c < NCH; c++) begin
				ctrl_ff[c] <= CTRL_RESET;
				cfg_ff[c] <= CFG_RESET;
				sa_ff[c] <= 32'h0;
				da_ff[c] <= 32'h0;
				llp_ff[c] <= 32'h0;
				sz_ff[c] <= 32'h0;
			end
		end else begin
			if (rd_ok) begin
				sa_ff[gnt_ff] <= next_addr(cur_sa, cur_ctrl[CT_SAD +: 2],
					sbytes);
				sz_ff[gnt_ff] <= (cur_sz - 32'h1) & SIZE_WMASK;
			end
			if (wr_ok) begin
				da_ff[gnt_ff] <= next_addr(cur_da, cur_ctrl[CT_DAD +: 2],
					dbytes);
			end
			if (stop_ch) begin
				ctrl_ff[gnt_ff][CT_EN] <= 1'b0;
			end
			if (s_wr_ff && sw_ch_hit) begin
				unique case (s_addr_ff[4:0])
					OFS_C_CTRL: begin
						ctrl_ff[sw_ch] <= (ctrl_ff[sw_ch] & ~CTRL_WMASK)
							| (hwdata & CTRL_WMASK);
						if (!ctrl_ff[sw_ch][CT_EN] && hwdata[CT_EN]) begin
							cfg_ff[sw_ch][CF_CHAIN +: 4] <= 4'h0;
						end
					end
					OFS_C_CFG: cfg_ff[sw_ch] <= (cfg_ff[sw_ch] & ~CFG_WMASK)
						| (hwdata & CFG_WMASK);
					OFS_C_SRC: sa_ff[sw_ch] <= hwdata;
					OFS_C_DST: da_ff[sw_ch] <= hwdata;
					OFS_C_LLP: llp_ff[sw_ch] <= hwdata & LLP_WMASK;
					OFS_C_SIZE: sz_ff[sw_ch] <= hwdata & SIZE_WMASK;
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Status flags; a hardware set wins over a software clear
	// ---------------------------------------------------------------
	logic [NCH-1:0] tc_clr, err_clr, abt_clr, abt_req, g_onehot;

	assign g_onehot = NCH'(1) << gnt_ff;
	assign tc_clr = (s_wr_ff && s_addr_ff == OFS_TC_CLR)
		? hwdata[NCH-1:0] : '0;
	assign err_clr = (s_wr_ff && s_addr_ff == OFS_EA_CLR)
		? hwdata[NCH-1:0] : '0;
	assign abt_clr = (s_wr_ff && s_addr_ff == OFS_EA_CLR)
		? hwdata[16 +: NCH] : '0;
	assign abt_req = (s_wr_ff && sw_ch_hit && s_addr_ff[4:0] == OFS_C_CTRL
		&& hwdata[CT_ABORT]) ? (NCH'(1) << sw_ch) : '0;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			tc_st_ff <= '0;
			err_st_ff <= '0;
			abt_st_ff <= '0;
			abort_pend_ff <= '0;
			tc_pulse_ff <= '0;
		end else begin
			tc_st_ff <= (tc_st_ff & ~tc_clr) | ((end_done
				&& !cur_ctrl[CT_TCSM]) ? g_onehot : '0);
			err_st_ff <= (err_st_ff & ~err_clr)
				| (bus_err ? g_onehot : '0);
			abt_st_ff <= (abt_st_ff & ~abt_clr)
				| (end_abort ? g_onehot : '0);
			abort_pend_ff <= (abort_pend_ff & ~(stop_ch ? g_onehot : '0))
				| abt_req;
			tc_pulse_ff <= end_done ? g_onehot : '0;
		end
	end

	// ---------------------------------------------------------------
	// FIFO pointers; flushed at each burst end and on error
	// ---------------------------------------------------------------
	logic push, pop;

	assign push = (state_ff == ST_PUSH);
	assign pop = (state_ff == ST_POP);

	always_ff @(posedge sys_clk) begin
		if (rst || state_ff == ST_END || bus_err) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
			cnt_ff <= '0;
		end else if (push) begin
			wptr_ff <= wptr_ff + FIFO_AW'(1);
			cnt_ff <= cnt_ff + (FIFO_AW + 1)'(1);
		end else if (pop) begin
			rptr_ff <= rptr_ff + FIFO_AW'(1);
			cnt_ff <= cnt_ff - (FIFO_AW + 1)'(1);
		end
	end

	dce_fifo_ram u_fifo (
		.sys_clk(sys_clk),
		.wr_en(push),
		.wr_addr(wptr_ff),
		.wr_data(rbuf_ff[7:0]),
		.rd_en(pop),
		.rd_addr(rptr_ff),
		.rd_data(fifo_rd_data)
	);

	// ---------------------------------------------------------------
	// Transfer sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff <= ST_ARB;
			gnt_ff <= '0;
			last_ff <= CH_W'(NCH - 1);
			burst_ff <= 9'h000;
			pix_ff <= 2'h0;
			rbuf_ff <= 32'h0;
			wbuf_ff <= 32'h0;
			m_addr_ff <= 32'h0;
			m_wdata_ff <= 32'h0;
			m_trans_ff <= HTRANS_IDLE;
			m_write_ff <= 1'b0;
			m_sel_ff <= 1'b0;
			m_size_ff <= WID_32;
			ack_ff <= '0;
		end else if (bus_err) begin
			m_trans_ff <= HTRANS_IDLE;
			state_ff <= ST_ARB;
		end else begin
			unique case (state_ff)
				ST_ARB: if (arb_hit) begin
					gnt_ff <= arb_ch;
					last_ff <= arb_ch;
					burst_ff <= burst_len(ctrl_ff[arb_ch][CT_BURST +: 3]);
					state_ff <= ST_WAIT;
				end
				ST_WAIT: if (abort_pend_ff[gnt_ff]) begin
					state_ff <= ST_END;
				end else if (!cur_ctrl[CT_EN]) begin
					state_ff <= ST_ARB;
				end else if ((!need_s || dma_req[srs])
					&& (!need_d || dma_req[drs])) begin
					state_ff <= ST_STEP;
				end
				ST_STEP: if (can_rd) begin
					m_addr_ff <= cur_sa;
					m_write_ff <= 1'b0;
					m_sel_ff <= cur_ctrl[CT_SSEL];
					m_size_ff <= width_hsize(cur_ctrl[CT_SW +: 3]);
					m_trans_ff <= HTRANS_NONSEQ;
					state_ff <= ST_RA;
				end else if (can_wr) begin
					wbuf_ff <= 32'h0;
					pix_ff <= 2'h0;
					state_ff <= ST_POP;
				end else if (no_more_rd) begin
					state_ff <= ST_END;
				end
				// Otherwise wait; only a threshold above half the FIFO stalls here
				ST_RA: if (m_hready) begin
					m_trans_ff <= HTRANS_IDLE;
					state_ff <= ST_RD;
				end
				ST_RD: if (m_hready) begin
					rbuf_ff <= m_hrdata >> {m_addr_ff[1:0], 3'h0};
					burst_ff <= burst_ff - 9'h001;
					pix_ff <= 2'h0;
					state_ff <= ST_PUSH;
				end
				ST_PUSH: begin
					rbuf_ff <= {8'h00, rbuf_ff[31:8]};
					pix_ff <= pix_ff + 2'h1;
					if ({1'b0, pix_ff} == sbytes - 3'h1) begin
						state_ff <= ST_STEP;
					end
				end
				ST_POP: state_ff <= ST_POPD;
				ST_POPD: begin
					wbuf_ff <= wword;
					pix_ff <= pix_ff + 2'h1;
					if ({1'b0, pix_ff} == dbytes - 3'h1) begin
						m_addr_ff <= cur_da;
						m_wdata_ff <= wword << {cur_da[1:0], 3'h0};
						m_write_ff <= 1'b1;
						m_sel_ff <= cur_ctrl[CT_DSEL];
						m_size_ff <= width_hsize(cur_ctrl[CT_DW +: 3]);
						m_trans_ff <= HTRANS_NONSEQ;
						state_ff <= ST_WA;
					end else begin
						state_ff <= ST_POP;
					end
				end
				ST_WA: if (m_hready) begin
					m_trans_ff <= HTRANS_IDLE;
					state_ff <= ST_WD;
				end
				ST_WD: if (m_hready) begin
					state_ff <= ST_STEP;
				end
				ST_END: if (need_s || need_d) begin
					ack_ff <= (need_s ? (REQ_LINES'(1) << srs) : '0)
						| (need_d ? (REQ_LINES'(1) << drs) : '0);
					state_ff <= ST_ACK;
				end else begin
					state_ff <= ST_ARB;
				end
				ST_ACK: if ((dma_req & ack_ff) == '0) begin
					ack_ff <= '0;
					state_ff <= ST_ARB;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- rtl/dce_fifo_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module dce_fifo_ram
	import dce_pkg::*;
(
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [FIFO_AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [FIFO_AW-1:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem [FIFO_DEPTH];

	// Byte store
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read port, data one cycle after rd_en
	always_ff @(posedge sys_clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule
`default_nettype wire

// ---- rtl/dce_pkg.sv ----
package dce_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NCH = 6;
	localparam int CH_W = 3;
	localparam int FIFO_AW = 3;
	localparam int FIFO_DEPTH = 8;
	localparam int REQ_LINES = 16;
	localparam int SIZE_W = 22;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [11:0] OFS_INT = 12'h000;
	localparam logic [11:0] OFS_INT_TC = 12'h004;
	localparam logic [11:0] OFS_TC_CLR = 12'h008;
	localparam logic [11:0] OFS_INT_EA = 12'h00c;
	localparam logic [11:0] OFS_EA_CLR = 12'h010;
	localparam logic [11:0] OFS_TC = 12'h014;
	localparam logic [11:0] OFS_EA = 12'h018;
	localparam logic [11:0] OFS_CHEN = 12'h01c;
	localparam logic [11:0] OFS_BUSY = 12'h020;
	localparam logic [11:0] OFS_CAP = 12'h034;
	localparam logic [3:0] OFS_CH_PAGE = 4'h1;
	localparam logic [4:0] OFS_C_CTRL = 5'h00;
	localparam logic [4:0] OFS_C_CFG = 5'h04;
	localparam logic [4:0] OFS_C_SRC = 5'h08;
	localparam logic [4:0] OFS_C_DST = 5'h0c;
	localparam logic [4:0] OFS_C_LLP = 5'h10;
	localparam logic [4:0] OFS_C_SIZE = 5'h14;

	// ---------------------------------------------------------------
	// Reset values and write masks
	// ---------------------------------------------------------------
	localparam logic [31:0] CAP_RESET = 32'h0000_6103;
	localparam logic [31:0] CTRL_RESET = 32'h0000_1200;
	localparam logic [31:0] CFG_RESET = 32'h0000_2087;
	localparam logic [31:0] CTRL_WMASK = 32'h87ff_3fff;
	localparam logic [31:0] CFG_WMASK = 32'h0000_3eff;
	localparam logic [31:0] LLP_WMASK = 32'hffff_fffd;
	localparam logic [31:0] SIZE_WMASK = 32'h003f_ffff;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CT_TCSM = 31;
	localparam int CT_TH = 24;
	localparam int CT_PRI = 22;
	localparam int CT_BURST = 16;
	localparam int CT_ABORT = 15;
	localparam int CT_SW = 11;
	localparam int CT_DW = 8;
	localparam int CT_MODE = 7;
	localparam int CT_SAD = 5;
	localparam int CT_DAD = 3;
	localparam int CT_SSEL = 2;
	localparam int CT_DSEL = 1;
	localparam int CT_EN = 0;
	localparam int CF_CHAIN = 16;
	localparam int CF_DHE = 13;
	localparam int CF_DRS = 9;
	localparam int CF_BUSY = 8;
	localparam int CF_SHE = 7;
	localparam int CF_SRS = 3;
	localparam int CF_ABTM = 2;
	localparam int CF_ERRM = 1;
	localparam int CF_TCM = 0;

	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] ADR_INC = 2'h0;
	localparam logic [1:0] ADR_DEC = 2'h1;
	localparam logic [2:0] WID_8 = 3'h0;
	localparam logic [2:0] WID_16 = 3'h1;
	localparam logic [2:0] WID_32 = 3'h2;
	localparam logic [1:0] HTRANS_IDLE = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	// Fixed request line per peripheral
	localparam logic [3:0] REQ_UART_TX = 4'h0;
	localparam logic [3:0] REQ_UART_RX = 4'h1;
	localparam logic [3:0] REQ_CODEC_IN = 4'h2;
	localparam logic [3:0] REQ_CODEC_OUT = 4'h3;
	localparam logic [3:0] REQ_AUDIO_RX = 4'h4;
	localparam logic [3:0] REQ_AUDIO_TX = 4'h5;
	localparam logic [3:0] REQ_USB_FIRST = 4'h6;
	localparam logic [3:0] REQ_USB_LAST = 4'hd;

	typedef enum logic [3:0] {
		ST_ARB, ST_WAIT, ST_STEP, ST_RA, ST_RD, ST_PUSH,
		ST_POP, ST_POPD, ST_WA, ST_WD, ST_END, ST_ACK
	} dce_state_t;

	// ---------------------------------------------------------------
	// Decoders
	// ---------------------------------------------------------------
	function automatic logic [4:0] th_decode(input logic [2:0] c);
		unique case (c)
			3'h1: th_decode = 5'h02;
			3'h2: th_decode = 5'h04;
			3'h3: th_decode = 5'h08;
			3'h4: th_decode = 5'h10;
			default: th_decode = 5'h01;
		endcase
	endfunction

	function automatic logic [8:0] burst_len(input logic [2:0] c);
		if (c == 3'h0) begin
			burst_len = 9'h001;
		end else begin
			burst_len = 9'h001 << ({1'b0, c} + 4'h1);
		end
	endfunction

	function automatic logic [2:0] width_bytes(input logic [2:0] w);
		unique case (w)
			WID_8: width_bytes = 3'h1;
			WID_16: width_bytes = 3'h2;
			default: width_bytes = 3'h4;
		endcase
	endfunction

	function automatic logic [2:0] width_hsize(input logic [2:0] w);
		unique case (w)
			WID_8: width_hsize = WID_8;
			WID_16: width_hsize = WID_16;
			default: width_hsize = WID_32;
		endcase
	endfunction

	function automatic logic [31:0] next_addr(input logic [31:0] a,
		input logic [1:0] ctl, input logic [2:0] b);
		unique case (ctl)
			ADR_INC: next_addr = a + {29'h0, b};
			ADR_DEC: next_addr = a - {29'h0, b};
			default: next_addr = a;
		endcase
	endfunction

endpackage
